// ### verilog/dcc_pkg.sv
// Package for the dual comparator control block: offsets, fields, resets, carriers
//
// Overview of operation
// - Two identical comparator control instances
// - Latched clocked output and raw async output
// - Disabled: pin output low, analog power off
// - Output edges set rise or fall flag
// - Flags hold until software writes zero
// - Mode bit 5 enables rising interrupt
// - Mode bit 4 enables falling interrupt
// - Control bit 6 reads live result
// - Control bit 7 enables the comparator
// - Control bits 3:2 drive positive hysteresis
// - Control bits 1:0 drive negative hysteresis
// - Mode bits 1:0 select response time
// - Mode bits 7:6, 3:2 read zero
package dcc_pkg;

  // Register offsets (byte bus address space)
  localparam logic [7:0] DCC_B_CONTROL_OFS = 8'h9A;
  localparam logic [7:0] DCC_A_CONTROL_OFS = 8'h9B;
  localparam logic [7:0] DCC_B_MODE_OFS    = 8'h9C;
  localparam logic [7:0] DCC_A_MODE_OFS    = 8'h9D;
  localparam logic [7:0] DCC_IRQ_STAT_OFS  = 8'hA0;
  localparam logic [7:0] DCC_IRQ_MASK_OFS  = 8'hA1;

  // Control register fields
  localparam int DCC_CTL_EN_BIT   = 7;
  localparam int DCC_CTL_OUT_BIT  = 6;
  localparam int DCC_CTL_RISE_BIT = 5;
  localparam int DCC_CTL_FALL_BIT = 4;
  localparam int DCC_CTL_HYP_LSB  = 2;
  localparam int DCC_CTL_HYN_LSB  = 0;

  // Mode register fields
  localparam int DCC_MOD_RIE_BIT  = 5;
  localparam int DCC_MOD_FIE_BIT  = 4;
  localparam int DCC_MOD_RESP_LSB = 0;

  // Interrupt status layout: bit 0 comparator A, bit 1 comparator B
  localparam int DCC_NUM_CMP = 2;

  // Reset values
  localparam logic [7:0] DCC_CONTROL_RST = 8'h00;
  localparam logic [7:0] DCC_MODE_RST    = 8'h02;
  localparam logic [1:0] DCC_RESP_RST    = 2'h2;
  localparam logic [1:0] DCC_MASK_RST    = 2'h0;

  // Register write carrier
  typedef struct packed {
    logic       ctl_we;
    logic       mode_we;
    logic [7:0] wdata;
  } dcc_wr_t;

  // Analog core control carrier
  typedef struct packed {
    logic       power_en;
    logic [1:0] pos_hyst;
    logic [1:0] neg_hyst;
    logic [1:0] resp_mode;
  } dcc_analog_t;

endpackage

// ### verilog/dcc_channel.sv
// One comparator control channel: registers, sync, edge flags, request
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
module dcc_channel (
  input  wire logic             clock_i,
  input  wire logic             srst_i,
  input  wire dcc_pkg::dcc_wr_t wr_i,
  input  wire logic             raw_result_i,
  output dcc_pkg::dcc_analog_t  analog_o,
  output logic [7:0]            control_o,
  output logic [7:0]            mode_o,
  output logic                  latched_out_o,
  output logic                  raw_out_o,
  output logic                  irq_req_o
);

  logic       enable_q;
  logic [1:0] pos_hyst_q;
  logic [1:0] neg_hyst_q;
  logic       rise_ie_q;
  logic       fall_ie_q;
  logic [1:0] resp_q;
  logic       sync1_q;
  logic       sync2_q;
  logic       prev_q;
  logic       rise_q;
  logic       fall_q;
  logic       rise_d;
  logic       fall_d;
  logic       rise_evt;
  logic       fall_evt;

  ////////////////////////////////////////////////////////////////////////
  // Control register writable fields
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      enable_q   <= 1'b0;
      pos_hyst_q <= 2'h0;
      neg_hyst_q <= 2'h0;
    end else if (wr_i.ctl_we) begin
      enable_q   <= wr_i.wdata[dcc_pkg::DCC_CTL_EN_BIT];
      pos_hyst_q <= wr_i.wdata[dcc_pkg::DCC_CTL_HYP_LSB +: 2];
      neg_hyst_q <= wr_i.wdata[dcc_pkg::DCC_CTL_HYN_LSB +: 2];
    end
  end

  // Mode register writable fields
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rise_ie_q <= 1'b0;
      fall_ie_q <= 1'b0;
      resp_q    <= dcc_pkg::DCC_RESP_RST;
    end else if (wr_i.mode_we) begin
      rise_ie_q <= wr_i.wdata[dcc_pkg::DCC_MOD_RIE_BIT];
      fall_ie_q <= wr_i.wdata[dcc_pkg::DCC_MOD_FIE_BIT];
      resp_q    <= wr_i.wdata[dcc_pkg::DCC_MOD_RESP_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser, then previous value for edges
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= raw_result_i;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Edge events, only counted while enabled
  assign rise_evt = enable_q & sync2_q & ~prev_q;
  assign fall_evt = enable_q & ~sync2_q & prev_q;

  // Sticky flags; an edge in the clearing cycle wins
  always_comb begin
    rise_d = rise_q;
    fall_d = fall_q;
    if (wr_i.ctl_we) begin
      rise_d = rise_q & wr_i.wdata[dcc_pkg::DCC_CTL_RISE_BIT];
      fall_d = fall_q & wr_i.wdata[dcc_pkg::DCC_CTL_FALL_BIT];
    end
    if (rise_evt) begin
      rise_d = 1'b1;
    end
    if (fall_evt) begin
      fall_d = 1'b1;
    end
  end

  // Flag storage
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  // Latched output register, low while disabled
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      latched_out_o <= 1'b0;
    end else begin
      latched_out_o <= enable_q & sync2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Raw path bypasses the clock so it works with the clock stopped
  assign raw_out_o          = enable_q & raw_result_i;
  assign analog_o           = '{power_en:  enable_q,
                                pos_hyst:  pos_hyst_q,
                                neg_hyst:  neg_hyst_q,
                                resp_mode: resp_q};
  assign irq_req_o          = (rise_q & rise_ie_q) | (fall_q & fall_ie_q);
  assign control_o = {enable_q, sync2_q & enable_q, rise_q, fall_q, pos_hyst_q, neg_hyst_q};
  assign mode_o    = {2'h0, rise_ie_q, fall_ie_q, 2'h0, resp_q};

endmodule

// ### verilog/dcc_top.sv
// Dual comparator control top: register port, two channels, interrupt
`timescale 1ns/10ps
module dcc_top (
  input  wire logic                 clock_i,
  input  wire logic                 srst_i,
  input  wire logic [7:0]           addr_i,
  input  wire logic [7:0]           wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic [7:0]                rdata_o,
  input  wire logic [1:0]           raw_result_i,
  output dcc_pkg::dcc_analog_t [1:0] analog_o,
  output logic [1:0]                latched_out_o,
  output logic [1:0]                raw_out_o,
  output logic [1:0]                cmp_irq_o,
  output logic                      irq_o
);

  logic [7:0]       ctl_ofs [2];
  logic [7:0]       mod_ofs [2];
  logic [7:0]       control [2];
  logic [7:0]       mode    [2];
  dcc_pkg::dcc_analog_t ana_ch [2];
  logic             lat_ch  [2];
  logic             raw_ch  [2];
  logic             req_ch  [2];
  logic [1:0]       req;
  logic [1:0]       req_prev_q;
  logic [1:0]       stat_q;
  logic [1:0]       stat_d;
  logic [1:0]       mask_q;
  logic [7:0]       rdata_d;

  assign ctl_ofs[0] = dcc_pkg::DCC_A_CONTROL_OFS;
  assign ctl_ofs[1] = dcc_pkg::DCC_B_CONTROL_OFS;
  assign mod_ofs[0] = dcc_pkg::DCC_A_MODE_OFS;
  assign mod_ofs[1] = dcc_pkg::DCC_B_MODE_OFS;

  ////////////////////////////////////////////////////////////////////////
  // Two identical channels
  for (genvar g = 0; g < dcc_pkg::DCC_NUM_CMP; g++) begin : g_ch
    dcc_pkg::dcc_wr_t wr;
    assign wr = '{ctl_we:  wr_i & (addr_i == ctl_ofs[g]),
                  mode_we: wr_i & (addr_i == mod_ofs[g]),
                  wdata:   wdata_i};
    dcc_channel u_ch (
      .clock_i       (clock_i),
      .srst_i        (srst_i),
      .wr_i          (wr),
      .raw_result_i  (raw_result_i[g]),
      .analog_o      (ana_ch[g]),
      .control_o     (control[g]),
      .mode_o        (mode[g]),
      .latched_out_o (lat_ch[g]),
      .raw_out_o     (raw_ch[g]),
      .irq_req_o     (req_ch[g])
    );
  end

  // Gather per-channel outputs, one driver per packed port
  assign analog_o      = {ana_ch[1], ana_ch[0]};
  assign latched_out_o = {lat_ch[1], lat_ch[0]};
  assign raw_out_o     = {raw_ch[1], raw_ch[0]};
  assign req           = {req_ch[1], req_ch[0]};
  assign cmp_irq_o     = req;

  ////////////////////////////////////////////////////////////////////////
  // Sticky status on request rise; read clears, set wins
  always_comb begin
    stat_d = stat_q;
    if (rd_i && addr_i == dcc_pkg::DCC_IRQ_STAT_OFS) begin
      stat_d = 2'h0;
    end
    stat_d = stat_d | (req & ~req_prev_q);
  end

  // Status, mask and request history
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      stat_q     <= 2'h0;
      req_prev_q <= 2'h0;
      mask_q     <= dcc_pkg::DCC_MASK_RST;
    end else begin
      stat_q     <= stat_d;
      req_prev_q <= req;
      if (wr_i && addr_i == dcc_pkg::DCC_IRQ_MASK_OFS) begin
        mask_q <= wdata_i[1:0];
      end
    end
  end

  assign irq_o = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////
  // Read mux, unmapped reads zero
  always_comb begin
    unique case (addr_i)
      dcc_pkg::DCC_A_CONTROL_OFS: rdata_d = control[0];
      dcc_pkg::DCC_B_CONTROL_OFS: rdata_d = control[1];
      dcc_pkg::DCC_A_MODE_OFS:    rdata_d = mode[0];
      dcc_pkg::DCC_B_MODE_OFS:    rdata_d = mode[1];
      dcc_pkg::DCC_IRQ_STAT_OFS:  rdata_d = {6'h00, stat_q};
      dcc_pkg::DCC_IRQ_MASK_OFS:  rdata_d = {6'h00, mask_q};
      default:                    rdata_d = 8'h00;
    endcase
  end

  // Read data register, valid only the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rdata_d;
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule

// ### sim/dcc_assertions.sv
// Port checker for the dual comparator control top, bound below
`timescale 1ns/10ps
module dcc_checker (
  input wire logic                       clock_i,
  input wire logic                       srst_i,
  input wire logic [7:0]                 addr_i,
  input wire logic [7:0]                 wdata_i,
  input wire logic                       wr_i,
  input wire logic                       rd_i,
  input wire logic [7:0]                 rdata_o,
  input wire logic [1:0]                 raw_result_i,
  input wire dcc_pkg::dcc_analog_t [1:0] analog_o,
  input wire logic [1:0]                 latched_out_o,
  input wire logic [1:0]                 raw_out_o,
  input wire logic [1:0]                 cmp_irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////
  a_raw_gated: assert property (raw_out_o == ({analog_o[1].power_en, analog_o[0].power_en} & raw_result_i))
    else $error("raw output not gated by enable");
  a_off_low: assert property (!analog_o[0].power_en |=> !latched_out_o[0])
    else $error("latched output high while off");
  a_sync_delay: assert property (analog_o[0].power_en |=> latched_out_o[0] == $past(raw_result_i[0], 3))
    else $error("latched output not three edges behind");
  a_ctl_write: assert property (wr_i && addr_i == 8'h9B |=>
    {analog_o[0].power_en, analog_o[0].pos_hyst, analog_o[0].neg_hyst} == {$past(wdata_i[7]), $past(wdata_i[3:0])})
    else $error("control write not applied");
  a_mode_write: assert property (wr_i && addr_i == 8'h9D |=> analog_o[0].resp_mode == $past(wdata_i[1:0]))
    else $error("response mode not applied");
  a_mode_read: assert property (rd_i && addr_i == 8'h9D |=>
    rdata_o[7:6] == 2'h0 && rdata_o[3:2] == 2'h0 && rdata_o[1:0] == analog_o[0].resp_mode)
    else $error("mode readback wrong");
  a_irq_cause: assert property ($rose(cmp_irq_o[0]) |-> $changed(latched_out_o[0]) || $past(wr_i) || $past(wr_i, 2))
    else $error("request rose without cause");
  a_irq_held: assert property ($fell(cmp_irq_o[0]) |-> $past(wr_i))
    else $error("request dropped without write");
  a_analog_hold: assert property (!$past(wr_i) |-> $stable(analog_o))
    else $error("analog controls moved without write");
endmodule
bind dcc_top dcc_checker u_chk (.clock_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .raw_result_i, .analog_o, .latched_out_o, .raw_out_o, .cmp_irq_o);

// ### sim/dcc_analog_model.sv
// Behavioural pair of analog comparator cores
`timescale 1ns/10ps
module dcc_analog_model (
  input  wire logic                       clock_i,
  input  wire logic                       srst_i,
  input  wire dcc_pkg::dcc_analog_t [1:0] analog_i,
  input  wire logic [1:0]                 level_i,
  output logic [1:0]                      raw_result_o
);
  logic [1:0] idle_q;
  // Unpowered core output wanders instead of holding
  always_ff @(posedge clock_i) begin
    idle_q <= srst_i ? 2'h0 : ~idle_q;
  end
  // Powered core follows the input comparison
  always_comb begin
    raw_result_o[0] = analog_i[0].power_en ? level_i[0] : idle_q[0];
    raw_result_o[1] = analog_i[1].power_en ? level_i[1] : idle_q[1];
  end
endmodule

// ### sim/dual_comparator_control_tb.sv
// Self-checking bench for the dual comparator control block
`timescale 1ns/10ps
module dual_comparator_control_tb;
  logic                       clock_i, srst_i, wr_i, rd_i, irq_o;
  logic [7:0]                 addr_i, wdata_i, rdata_o;
  logic [1:0]                 raw_result_i, level, latched_out_o, raw_out_o, cmp_irq_o;
  dcc_pkg::dcc_analog_t [1:0] analog_o;
  int                         n_mismatch, comparisons;
  dcc_top u_dut (.clock_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .raw_result_i,
    .analog_o, .latched_out_o, .raw_out_o, .cmp_irq_o, .irq_o);
  dcc_analog_model u_core (.clock_i, .srst_i, .analog_i(analog_o), .level_i(level), .raw_result_o(raw_result_i));
  ////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    cyc(1);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clock_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    cyc(1);
    rd_i <= 1'b0;
    chk("rdata", rdata_o, e);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(8'h9B, 8'h00);
    rd(8'h9D, 8'h02);
    rd(8'h9A, 8'h00);
    rd(8'h9C, 8'h02);
    rd(8'h55, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_codes;
    for (int c = 0; c < 4; c++) begin
      wr(8'h9D, 8'hCC | 8'(c));
      rd(8'h9D, 8'(c));
      chk("resp", 8'(analog_o[0].resp_mode), 8'(c));
      wr(8'h9B, 8'h40 | 8'(c * 4 + 3 - c));
      rd(8'h9B, 8'(c * 4 + 3 - c));
      chk("hyst", 8'({analog_o[0].pos_hyst, analog_o[0].neg_hyst}), 8'(c * 4 + 3 - c));
    end
    $display("codes test done");
  endtask
  task automatic t_edges;
    wr(8'h9B, 8'h80);
    cyc(6);
    wr(8'h9B, 8'h80);
    wr(8'h9D, 8'h30);
    wr(8'hA1, 8'h01);
    level[0] <= 1'b1;
    cyc(5);
    rd(8'h9B, 8'hE0);
    chk("irq", 8'({cmp_irq_o, irq_o}), 8'h03);
    level[0] <= 1'b0;
    cyc(5);
    rd(8'h9B, 8'hB0);
    rd(8'hA0, 8'h01);
    cyc(2);
    chk("irq clear", 8'(irq_o), 8'h00);
    wr(8'h9D, 8'h10);
    wr(8'h9B, 8'hA0);
    chk("masked", 8'(cmp_irq_o), 8'h00);
    rd(8'h9B, 8'hA0);
    $display("edges test done");
  endtask
  task automatic t_disable;
    level[1] <= 1'b1;
    wr(8'h9A, 8'h80);
    cyc(5);
    chk("b on", 8'({latched_out_o[1], raw_out_o[1]}), 8'h03);
    wr(8'h9A, 8'h00);
    cyc(2);
    chk("b off", 8'({analog_o[1].power_en, latched_out_o[1], raw_out_o[1]}), 8'h00);
    $display("disable test done");
  endtask
  task automatic t_midreset;
    srst_i <= 1'b1;
    cyc(3);
    srst_i <= 1'b0;
    chk("irq rst", 8'({cmp_irq_o, irq_o}), 8'h00);
    chk("ana rst", 8'(analog_o[0]), 8'h02);
    t_reset();
    $display("midreset test done");
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    srst_i      = 1'b1;
    wr_i        = 1'b0;
    rd_i        = 1'b0;
    addr_i      = 8'h00;
    wdata_i     = 8'h00;
    level       = 2'h0;
    n_mismatch  = 0;
    comparisons = 0;
    repeat (12) @(posedge clock_i);
    srst_i <= 1'b0;
    t_reset();
    t_codes();
    t_edges();
    t_disable();
    t_midreset();
    print_verdict();
  end
  // Hang guard
  initial begin
    #1000000;
    n_mismatch++;
    print_verdict();
  end
endmodule
